// File: dbuf_pkg.sv
// constants and carrier types for the data buffer transfer block
`default_nettype none
package dbuf_pkg;

    // data memory nibbles of the buffer, bank 0, 0CH is the top group
    localparam logic [3:0] DM_BUF_FIRST   = 4'hC;
    localparam logic [3:0] DM_BUF_LAST    = 4'hF;

    // register file (control registers and port selection)
    localparam logic [6:0] RF_TABLE_WIDTH = 7'h07;
    localparam logic [6:0] RF_CTRL_LAST   = 7'h3F;
    localparam logic [6:0] RF_PORT0A_DIR  = 7'h6F;
    localparam int         TW_BYTE_BIT    = 0;

    // peripheral addresses
    localparam logic [6:0] PA_CONV_REF    = 7'h02;
    localparam logic [6:0] PA_SERIAL0     = 7'h03;
    localparam logic [6:0] PA_SERIAL1     = 7'h04;
    localparam logic [6:0] PA_T0_MOD      = 7'h1A;
    localparam logic [6:0] PA_T0_CNT      = 7'h1B;
    localparam logic [6:0] PA_T1_MOD      = 7'h1C;
    localparam logic [6:0] PA_T1_CNT      = 7'h1D;
    localparam logic [6:0] PA_T2_MOD      = 7'h1E;
    localparam logic [6:0] PA_T2_CNT      = 7'h1F;
    localparam logic [6:0] PA_TABLE_PTR   = 7'h40;
    localparam logic [6:0] PA_SAVE_STACK  = 7'h41;
    localparam logic [6:0] PA_SYNTH_DIV   = 7'h42;
    localparam logic [6:0] PA_IF_COUNT    = 7'h43;
    localparam logic [6:0] PA_PWM0        = 7'h44;
    localparam logic [6:0] PA_PWM1        = 7'h45;
    localparam logic [6:0] PA_PWM2        = 7'h46;
    localparam logic [6:0] PA_TIMER3_MOD  = PA_PWM2;

    // values after reset
    localparam logic [15:0] RST_CONV_REF  = 16'h0000;
    localparam logic [15:0] RST_SERIAL    = 16'h0000;
    localparam logic [15:0] RST_TMOD      = 16'h00FF;
    localparam logic [15:0] RST_PTR       = 16'h0000;
    localparam logic [15:0] RST_STACK     = 16'h0000;
    localparam logic [15:0] RST_SYNTH     = 16'h0000;
    localparam logic [15:0] RST_PWM       = 16'h01FF;
    localparam logic [3:0]  RST_PORT_DIR  = 4'h0;
    localparam logic        RST_WIDTH8    = 1'b0;
    localparam logic [15:0] RST_BUFFER    = 16'h0000;

    // value returned where the read is unspecified
    localparam logic [3:0]  UNDEF_NIB     = 4'h0;
    localparam logic [15:0] UNDEF_WORD    = 16'h0000;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FETCH = 2'b01
    } fetch_state_t;

    typedef struct packed {
        logic [7:0]  conv_ref;
        logic [7:0]  serial0;
        logic [7:0]  serial1;
        logic [7:0]  t0_mod;
        logic [7:0]  t1_mod;
        logic [7:0]  t2_mod;
        logic [15:0] table_pointer;
        logic [15:0] save_stack;
        logic [15:0] synth_div;
        logic [8:0]  pwm0;
        logic [8:0]  pwm1;
        logic [8:0]  pwm2;
    } periph_regs_t;

    typedef struct packed {
        logic [7:0]  t0;
        logic [7:0]  t1;
        logic [7:0]  t2;
        logic [15:0] if_count;
    } periph_counts_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [6:0] addr;
    } periph_req_t;

    typedef struct packed {
        logic       we;
        logic       re;
        logic       bank0;
        logic [3:0] addr;
        logic [3:0] wdata;
    } dm_req_t;

    typedef struct packed {
        logic       we;
        logic       re;
        logic [6:0] addr;
        logic [3:0] wdata;
    } rf_req_t;

endpackage
`default_nettype wire

// File: masked_reg.sv
// one peripheral register slot loaded from the low bits of the buffer
`timescale 1ns/1ps
`default_nettype none
module masked_reg
    import dbuf_pkg::*;
#(
    parameter int          W       = 8,
    parameter logic [15:0] RST_VAL = 16'h0000
)
(
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic         we,
    input  wire logic [15:0]  wdata,
    output logic      [W-1:0] q_ff
);

    typedef struct packed {
        logic [W-1:0] q;
    } slot_t;

    slot_t cur_ff;
    slot_t nxt_cur;

    if (W < 1 || W > 16)
    begin : g_bad_width
        $error("masked_reg width must be 1 to 16");
    end

    always_comb
    begin
        nxt_cur = cur_ff;
        if (we)
        begin
            // high buffer bits beyond the slot are dropped
            nxt_cur.q = wdata[W-1:0]; // RL20
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            cur_ff.q <= RST_VAL[W-1:0];
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end

    assign q_ff = cur_ff.q;

endmodule // masked_reg
`default_nettype wire

// File: data_buffer_peripheral_xfer.sv
// data buffer, table fetch and peripheral transfer logic
//
// Functional notes
// RL1 - port 0A direction bits: 0 input, 1 output
// RL2 - write-only control register reads are unspecified
// RL3 - writes to read-only registers change nothing
// RL4 - unassigned locations: unspecified read, ignored write
// RL5 - buffer is four bank 0 nibbles 0CH-0FH
// RL6 - nibble 0CH is the top, 0FH bottom
// RL7 - data memory accesses reach buffer nibbles directly
// RL8 - table fetch loads word at table pointer
// RL9 - fetch width follows width select register
// RL10 - byte fetch fills the two low groups
// RL11 - table fetch holds one stack level
// RL12 - table fetch reaches every program address
// RL13 - peripheral read copies register into buffer
// RL14 - peripheral write copies buffer into register
// RL15 - 02H, 03H, 04H are read/write
// RL16 - 1AH read/write, 1BH count read only
// RL17 - 1CH, 1EH read/write; 1DH, 1FH read only
// RL18 - 43H counter readable, write not supported
// RL19 - timer 3 modulo shares the third duty slot
// RL20 - excess high buffer bits ignored on write
`timescale 1ns/1ps
`default_nettype none
module data_buffer_peripheral_xfer
    import dbuf_pkg::*;
(
    input  wire logic           mclk,
    input  wire logic           rst,
    input  wire dm_req_t        dm_req,
    output logic [3:0]          dm_rdata,
    input  wire rf_req_t        rf_req,
    output logic [3:0]          rf_rdata,
    input  wire logic           tf_start,
    output logic                pm_req,
    output logic [15:0]         pm_addr,
    input  wire logic           pm_ack,
    input  wire logic [15:0]    pm_rdata,
    output logic                stack_hold,
    output logic                tf_done,
    input  wire periph_req_t    po_req,
    output logic                po_done,
    input  wire periph_counts_t counts,
    output periph_regs_t        regs,
    output logic [3:0]          port0a_dir,
    output logic [15:0]         xfer_buffer
);

    typedef struct packed {
        fetch_state_t fst;
        logic [15:0]  xbuf;
        logic [3:0]   dm_rdata;
        logic [3:0]   rf_rdata;
        logic         width8;
        logic [3:0]   port_dir;
        logic         pm_req;
        logic [15:0]  pm_addr;
        logic         stack_hold;
        logic         tf_done;
        logic         po_done;
    } state_t;

    state_t cur_ff;
    state_t nxt_cur;

    logic        dm_hit;
    logic [1:0]  dm_grp;
    logic        po_wr;
    logic        po_rd;
    logic        fetch_load;
    logic [15:0] po_rdata;
    logic        po_rhit;

    // group index: 0CH -> 3 (top), 0FH -> 0
    assign dm_hit = dm_req.bank0 && (dm_req.addr >= DM_BUF_FIRST); // RL5
    assign dm_grp = 2'(DM_BUF_LAST - dm_req.addr); // RL6
    assign po_wr  = po_req.valid && po_req.write;
    assign po_rd  = po_req.valid && !po_req.write;
    assign fetch_load = (cur_ff.fst == ST_FETCH) && pm_ack;

    // read side of the peripheral space, zero extended to 16 bits
    always_comb
    begin
        po_rhit  = 1'b1;
        po_rdata = UNDEF_WORD;
        case (po_req.addr)
            PA_CONV_REF:   po_rdata = {8'h00, regs.conv_ref}; // RL15
            PA_SERIAL0:    po_rdata = {8'h00, regs.serial0}; // RL15
            PA_SERIAL1:    po_rdata = {8'h00, regs.serial1}; // RL15
            PA_T0_MOD:     po_rdata = {8'h00, regs.t0_mod}; // RL16
            PA_T0_CNT:     po_rdata = {8'h00, counts.t0}; // RL16
            PA_T1_MOD:     po_rdata = {8'h00, regs.t1_mod}; // RL17
            PA_T1_CNT:     po_rdata = {8'h00, counts.t1}; // RL17
            PA_T2_MOD:     po_rdata = {8'h00, regs.t2_mod}; // RL17
            PA_T2_CNT:     po_rdata = {8'h00, counts.t2}; // RL17
            PA_TABLE_PTR:  po_rdata = regs.table_pointer;
            PA_SAVE_STACK: po_rdata = regs.save_stack;
            PA_SYNTH_DIV:  po_rdata = regs.synth_div;
            PA_IF_COUNT:   po_rdata = counts.if_count; // RL18
            PA_PWM0:       po_rdata = {7'h00, regs.pwm0};
            PA_PWM1:       po_rdata = {7'h00, regs.pwm1};
            PA_PWM2:       po_rdata = {7'h00, regs.pwm2}; // RL19
            default:
            begin
                // unused address: buffer is left alone
                po_rhit  = 1'b0; // RL4
                po_rdata = UNDEF_WORD;
            end
        endcase
    end

    always_comb
    begin
        nxt_cur            = cur_ff;
        nxt_cur.tf_done    = 1'b0;
        nxt_cur.po_done    = po_req.valid;
        nxt_cur.dm_rdata   = UNDEF_NIB;
        nxt_cur.rf_rdata   = UNDEF_NIB;

        // data memory path, lowest priority on the buffer
        if (dm_req.re && dm_hit)
        begin
            nxt_cur.dm_rdata = cur_ff.xbuf[4*dm_grp +: 4]; // RL7
        end
        if (dm_req.we && dm_hit)
        begin
            nxt_cur.xbuf[4*dm_grp +: 4] = dm_req.wdata; // RL7
        end

        // register file: only 07H and 6FH exist here
        if (rf_req.re)
        begin
            case (rf_req.addr)
                RF_TABLE_WIDTH: nxt_cur.rf_rdata = {3'b000, cur_ff.width8};
                RF_PORT0A_DIR:  nxt_cur.rf_rdata = cur_ff.port_dir; // RL1
                default:        nxt_cur.rf_rdata = UNDEF_NIB; // RL2 RL4
            endcase
        end
        if (rf_req.we)
        begin
            case (rf_req.addr)
                RF_TABLE_WIDTH:
                begin
                    nxt_cur.width8 = rf_req.wdata[TW_BYTE_BIT]; // RL9
                end
                RF_PORT0A_DIR:
                begin
                    nxt_cur.port_dir = rf_req.wdata; // RL1
                end
                default:
                begin
                    nxt_cur.width8 = cur_ff.width8; // RL3 RL4
                end
            endcase
        end

        // peripheral read overrides a same-cycle nibble write
        if (po_rd && po_rhit)
        begin
            nxt_cur.xbuf = po_rdata; // RL13
        end

        case (cur_ff.fst)
            ST_IDLE:
            begin
                if (tf_start)
                begin
                    nxt_cur.fst        = ST_FETCH;
                    nxt_cur.pm_req     = 1'b1;
                    nxt_cur.pm_addr    = regs.table_pointer; // RL12
                    nxt_cur.stack_hold = 1'b1; // RL11
                end
            end
            ST_FETCH:
            begin
                if (pm_ack)
                begin
                    nxt_cur.fst        = ST_IDLE;
                    nxt_cur.pm_req     = 1'b0;
                    nxt_cur.stack_hold = 1'b0;
                    nxt_cur.tf_done    = 1'b1;
                    if (cur_ff.width8)
                    begin
                        nxt_cur.xbuf[7:0] = pm_rdata[7:0]; // RL10
                    end
                    else
                    begin
                        nxt_cur.xbuf = pm_rdata; // RL8
                    end
                end
            end
            default:
            begin
                nxt_cur.fst        = ST_IDLE;
                nxt_cur.pm_req     = 1'b0;
                nxt_cur.stack_hold = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            cur_ff.fst        <= ST_IDLE;
            cur_ff.xbuf       <= RST_BUFFER;
            cur_ff.dm_rdata   <= UNDEF_NIB;
            cur_ff.rf_rdata   <= UNDEF_NIB;
            cur_ff.width8     <= RST_WIDTH8;
            cur_ff.port_dir   <= RST_PORT_DIR;
            cur_ff.pm_req     <= 1'b0;
            cur_ff.pm_addr    <= RST_PTR;
            cur_ff.stack_hold <= 1'b0;
            cur_ff.tf_done    <= 1'b0;
            cur_ff.po_done    <= 1'b0;
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end

    assign dm_rdata    = cur_ff.dm_rdata;
    assign rf_rdata    = cur_ff.rf_rdata;
    assign pm_req      = cur_ff.pm_req;
    assign pm_addr     = cur_ff.pm_addr;
    assign stack_hold  = cur_ff.stack_hold;
    assign tf_done     = cur_ff.tf_done;
    assign po_done     = cur_ff.po_done;
    assign port0a_dir  = cur_ff.port_dir;
    assign xfer_buffer = cur_ff.xbuf;

    // writable peripheral slots; counters and 43H have no slot at all
    masked_reg #(.W(8), .RST_VAL(RST_CONV_REF)) u_conv_ref (
        .mclk(mclk), .rst(rst), .wdata(cur_ff.xbuf),
        .we(po_wr && po_req.addr == PA_CONV_REF), // RL14 RL15
        .q_ff(regs.conv_ref));
    masked_reg #(.W(8), .RST_VAL(RST_SERIAL)) u_serial0 (
        .mclk(mclk), .rst(rst), .wdata(cur_ff.xbuf),
        .we(po_wr && po_req.addr == PA_SERIAL0), // RL15
        .q_ff(regs.serial0));
    masked_reg #(.W(8), .RST_VAL(RST_SERIAL)) u_serial1 (
        .mclk(mclk), .rst(rst), .wdata(cur_ff.xbuf),
        .we(po_wr && po_req.addr == PA_SERIAL1), // RL15
        .q_ff(regs.serial1));
    masked_reg #(.W(8), .RST_VAL(RST_TMOD)) u_t0_mod (
        .mclk(mclk), .rst(rst), .wdata(cur_ff.xbuf),
        .we(po_wr && po_req.addr == PA_T0_MOD), // RL16
        .q_ff(regs.t0_mod));
    masked_reg #(.W(8), .RST_VAL(RST_TMOD)) u_t1_mod (
        .mclk(mclk), .rst(rst), .wdata(cur_ff.xbuf),
        .we(po_wr && po_req.addr == PA_T1_MOD), // RL17
        .q_ff(regs.t1_mod));
    masked_reg #(.W(8), .RST_VAL(RST_TMOD)) u_t2_mod (
        .mclk(mclk), .rst(rst), .wdata(cur_ff.xbuf),
        .we(po_wr && po_req.addr == PA_T2_MOD), // RL17
        .q_ff(regs.t2_mod));
    masked_reg #(.W(16), .RST_VAL(RST_PTR)) u_table_pointer (
        .mclk(mclk), .rst(rst), .wdata(cur_ff.xbuf),
        .we(po_wr && po_req.addr == PA_TABLE_PTR),
        .q_ff(regs.table_pointer));
    masked_reg #(.W(16), .RST_VAL(RST_STACK)) u_save_stack (
        .mclk(mclk), .rst(rst), .wdata(cur_ff.xbuf),
        .we(po_wr && po_req.addr == PA_SAVE_STACK),
        .q_ff(regs.save_stack));
    masked_reg #(.W(16), .RST_VAL(RST_SYNTH)) u_synth_div (
        .mclk(mclk), .rst(rst), .wdata(cur_ff.xbuf),
        .we(po_wr && po_req.addr == PA_SYNTH_DIV),
        .q_ff(regs.synth_div));
    masked_reg #(.W(9), .RST_VAL(RST_PWM)) u_pwm0 (
        .mclk(mclk), .rst(rst), .wdata(cur_ff.xbuf),
        .we(po_wr && po_req.addr == PA_PWM0), // RL20
        .q_ff(regs.pwm0));
    masked_reg #(.W(9), .RST_VAL(RST_PWM)) u_pwm1 (
        .mclk(mclk), .rst(rst), .wdata(cur_ff.xbuf),
        .we(po_wr && po_req.addr == PA_PWM1),
        .q_ff(regs.pwm1));
    // timer 3 modulo is the low byte of this shared slot
    masked_reg #(.W(9), .RST_VAL(RST_PWM)) u_pwm2 (
        .mclk(mclk), .rst(rst), .wdata(cur_ff.xbuf),
        .we(po_wr && po_req.addr == PA_TIMER3_MOD), // RL19
        .q_ff(regs.pwm2));

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence s_fetch_begin;
        cur_ff.fst == ST_IDLE && tf_start;
    endsequence

    sequence s_fetch_open;
        pm_req && stack_hold && pm_addr == $past(regs.table_pointer);
    endsequence

    chk_port_dir_write: assert property ( // RL1
        rf_req.we && rf_req.addr == RF_PORT0A_DIR
        |=> port0a_dir == $past(rf_req.wdata))
        else $error("port 0A direction not written");

    chk_unmapped_rf_read: assert property ( // RL4
        rf_req.re && rf_req.addr != RF_TABLE_WIDTH
        && rf_req.addr != RF_PORT0A_DIR
        |=> rf_rdata == UNDEF_NIB)
        else $error("unassigned location read wrong");

    chk_ro_write_quiet: assert property ( // RL3
        po_wr && (po_req.addr == PA_T0_CNT || po_req.addr == PA_IF_COUNT)
        |=> $stable(regs))
        else $error("read-only write changed a register");

    chk_nibble_order: assert property ( // RL6
        dm_req.re && dm_req.bank0 && dm_req.addr == DM_BUF_FIRST
        |=> dm_rdata == $past(xfer_buffer[15:12]))
        else $error("top nibble not bits 15 to 12");

    chk_dm_nibble_write: assert property ( // RL7
        dm_req.we && dm_req.bank0 && dm_req.addr == DM_BUF_LAST
        && !po_rd && !fetch_load
        |=> xfer_buffer[3:0] == $past(dm_req.wdata))
        else $error("bottom nibble not written");

    chk_fetch_open: assert property ( // RL11
        s_fetch_begin |=> s_fetch_open)
        else $error("table fetch did not start");

    chk_hold_span: assert property ( // RL11
        stack_hold |-> cur_ff.fst == ST_FETCH && pm_req)
        else $error("stack level held outside fetch");

    chk_fetch_word: assert property ( // RL8
        fetch_load && !cur_ff.width8
        |=> xfer_buffer == $past(pm_rdata) && tf_done && !stack_hold)
        else $error("word fetch not loaded");

    chk_fetch_byte: assert property ( // RL10
        fetch_load && cur_ff.width8
        |=> xfer_buffer[7:0] == $past(pm_rdata[7:0])
        && xfer_buffer[15:8] == $past(xfer_buffer[15:8]))
        else $error("byte fetch misplaced");

    chk_count_read: assert property ( // RL16
        po_rd && po_req.addr == PA_T0_CNT && !fetch_load
        |=> xfer_buffer == {8'h00, $past(counts.t0)} && po_done)
        else $error("timer 0 count not read");

    chk_ifc_read: assert property ( // RL18
        po_rd && po_req.addr == PA_IF_COUNT && !fetch_load
        |=> xfer_buffer == $past(counts.if_count))
        else $error("frequency counter not read");

    chk_mod_write: assert property ( // RL14
        po_wr && po_req.addr == PA_T0_MOD
        |=> regs.t0_mod == $past(xfer_buffer[7:0]))
        else $error("timer 0 modulo not written");

endmodule // data_buffer_peripheral_xfer
`default_nettype wire

// File: pm_model.sv
// program memory model answering table fetch requests
`timescale 1ns/1ps
`default_nettype none
module pm_model
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [3:0]  lat,
    input  wire logic        pm_req,
    input  wire logic [15:0] pm_addr,
    output logic             pm_ack,
    output logic [15:0]      pm_rdata
);
    logic [3:0] wait_ff;

    // data lines toggle when not answering so stale words never match
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pm_ack   <= 1'b0;
            pm_rdata <= 16'h0F0F;
            wait_ff  <= 4'h0;
        end
        else if (pm_ack)
        begin
            pm_ack   <= 1'b0;
            pm_rdata <= ~pm_rdata;
            wait_ff  <= 4'h0;
        end
        else if (pm_req && wait_ff == lat)
        begin
            pm_ack   <= 1'b1;
            pm_rdata <= pm_addr ^ 16'h5A3C;
        end
        else
        begin
            wait_ff  <= pm_req ? wait_ff + 4'h1 : 4'h0;
            pm_rdata <= ~pm_rdata;
        end
    end
endmodule // pm_model
`default_nettype wire

// File: tb_data_buffer_peripheral_xfer.sv
// self-checking bench for the data buffer transfer block
`timescale 1ns/1ps
`default_nettype none
module tb_data_buffer_peripheral_xfer;
    import dbuf_pkg::*;

    typedef struct packed {
        logic [6:0]  a;
        logic [15:0] w;
        logic [15:0] r;
    } row_t;

    logic           mclk;
    logic           rst;
    dm_req_t        dm_req;
    logic [3:0]     dm_rdata;
    rf_req_t        rf_req;
    logic [3:0]     rf_rdata;
    logic           tf_start;
    logic           pm_req;
    logic [15:0]    pm_addr;
    logic           pm_ack;
    logic [15:0]    pm_rdata;
    logic           stack_hold;
    logic           tf_done;
    periph_req_t    po_req;
    logic           po_done;
    periph_counts_t counts;
    periph_regs_t   regs;
    periph_regs_t   snap;
    logic [3:0]     port0a_dir;
    logic [15:0]    xfer_buffer;
    logic [3:0]     lat;
    int             num_errors;
    int             checks_done;
    row_t           rows [10];

    data_buffer_peripheral_xfer data_buffer_peripheral_xfer_inst (
        .mclk(mclk), .rst(rst), .dm_req(dm_req), .dm_rdata(dm_rdata),
        .rf_req(rf_req), .rf_rdata(rf_rdata), .tf_start(tf_start),
        .pm_req(pm_req), .pm_addr(pm_addr), .pm_ack(pm_ack),
        .pm_rdata(pm_rdata), .stack_hold(stack_hold), .tf_done(tf_done),
        .po_req(po_req), .po_done(po_done), .counts(counts), .regs(regs),
        .port0a_dir(port0a_dir), .xfer_buffer(xfer_buffer));

    pm_model pm_model_inst (
        .mclk(mclk), .rst(rst), .lat(lat), .pm_req(pm_req),
        .pm_addr(pm_addr), .pm_ack(pm_ack), .pm_rdata(pm_rdata));

    always #5 mclk = ~mclk;

    task automatic tick();
        @(posedge mclk);
        #1;
    endtask

    task automatic check(input string nm, input logic [127:0] seen,
                         input logic [127:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // buffer loaded through the data memory path, top nibble first
    task automatic load_buf(input logic [15:0] v);
        for (int i = 0; i < 4; i++)
        begin
            dm_req = '{we: 1'b1, re: 1'b0, bank0: 1'b1,
                       addr: 4'hC + 4'(i), wdata: v[15-4*i -: 4]};
            tick();
        end
        dm_req = '0;
        tick();
    endtask

    task automatic dm_rd(input logic [3:0] a, input logic b0,
                         input logic [3:0] exp);
        dm_req = '{we: 1'b0, re: 1'b1, bank0: b0, addr: a, wdata: 4'h0};
        tick();
        check("dm_rdata", dm_rdata, exp);
        dm_req = '0;
        tick();
    endtask

    task automatic rf_op(input logic w, input logic [6:0] a,
                         input logic [3:0] d, input logic [3:0] exp);
        rf_req = '{we: w, re: !w, addr: a, wdata: d};
        tick();
        if (!w)
            check("rf_rdata", rf_rdata, exp);
        rf_req = '0;
        tick();
    endtask

    task automatic po(input logic w, input logic [6:0] a);
        po_req = '{valid: 1'b1, write: w, addr: a};
        tick();
        check("po_done", po_done, 1'b1);
        po_req = '0;
        tick();
    endtask

    task automatic fetch(input logic [3:0] l, input logic [15:0] ptr,
                         input logic [15:0] exp);
        int n;
        lat = l;
        tf_start = 1'b1;
        tick();
        tf_start = 1'b0;
        check("pm_addr", pm_addr, ptr);
        check("pm_req", pm_req, 1'b1);
        check("stack_hold", stack_hold, 1'b1);
        n = 0;
        while (tf_done !== 1'b1 && n < 20)
        begin
            tick();
            n++;
        end
        check("tf_done", tf_done, 1'b1);
        check("fetched", xfer_buffer, exp);
        check("stack_free", stack_hold, 1'b0);
        check("pm_idle", pm_req, 1'b0);
        tick();
    endtask

    initial
    begin
        #50000;
        num_errors++;
        final_report();
    end

    initial
    begin
        mclk = 1'b0;
        rst = 1'b1;
        dm_req = '0;
        rf_req = '0;
        po_req = '0;
        tf_start = 1'b0;
        lat = 4'h0;
        counts = '{t0: 8'h77, t1: 8'h81, t2: 8'h92, if_count: 16'hC3E1};
        num_errors = 0;
        checks_done = 0;
        rows = '{'{7'h02, 16'hABCD, 16'h00CD}, '{7'h03, 16'h1234, 16'h0034},
                 '{7'h04, 16'h5678, 16'h0078}, '{7'h1A, 16'hFF5A, 16'h005A},
                 '{7'h1C, 16'h3C6B, 16'h006B}, '{7'h1E, 16'h0E19, 16'h0019},
                 '{7'h40, 16'hBEEF, 16'hBEEF}, '{7'h41, 16'h8421, 16'h8421},
                 '{7'h42, 16'h7E81, 16'h7E81}, '{7'h44, 16'hFFFF, 16'h01FF}};
        repeat (4) @(posedge mclk);
        #1;
        rst = 1'b0;
        check("buf_rst", xfer_buffer, 16'h0000);
        check("dir_rst", port0a_dir, 4'h0);
        check("tmod_rst", regs.t0_mod, 8'hFF);
        check("pwm_rst", regs.pwm0, 9'h1FF);
        $display("test reset done");
        // write, clear, read back each slot except 45H and 46H
        foreach (rows[i])
        begin
            load_buf(rows[i].w);
            po(1'b1, rows[i].a);
            load_buf(16'h0000);
            po(1'b0, rows[i].a);
            check("get", xfer_buffer, rows[i].r);
        end
        $display("test table done");
        load_buf(16'h1234);
        dm_rd(4'hC, 1'b1, 4'h1);
        dm_rd(4'hF, 1'b1, 4'h4);
        dm_rd(4'hC, 1'b0, 4'h0);
        $display("test layout done");
        rf_op(1'b1, RF_PORT0A_DIR, 4'h5, 4'h0);
        check("dir", port0a_dir, 4'h5);
        rf_op(1'b0, RF_PORT0A_DIR, 4'h0, 4'h5);
        rf_op(1'b1, 7'h10, 4'hF, 4'h0);
        check("dir_kept", port0a_dir, 4'h5);
        rf_op(1'b0, 7'h10, 4'h0, 4'h0);
        $display("test regfile done");
        // shared duty slot, then read-only and unmapped slots
        load_buf(16'h1E3C);
        po(1'b1, 7'h46);
        check("shared", regs.pwm2, 9'h03C);
        load_buf(16'hAAAA);
        snap = regs;
        po(1'b1, 7'h1B);
        po(1'b1, 7'h43);
        po(1'b1, 7'h7F);
        check("ro_write", regs, snap);
        po(1'b0, 7'h7F);
        check("unmapped", xfer_buffer, 16'hAAAA);
        po(1'b0, 7'h1B);
        check("t0", xfer_buffer, 16'h0077);
        po(1'b0, 7'h1D);
        check("t1", xfer_buffer, 16'h0081);
        po(1'b0, 7'h1F);
        check("t2", xfer_buffer, 16'h0092);
        po(1'b0, 7'h43);
        check("ifc", xfer_buffer, 16'hC3E1);
        // periph read beats a nibble write in the same cycle
        load_buf(16'h0000);
        dm_req = '{we: 1'b1, re: 1'b0, bank0: 1'b1, addr: 4'hF,
                   wdata: 4'h5};
        po_req = '{valid: 1'b1, write: 1'b0, addr: PA_T0_CNT};
        tick();
        dm_req = '0;
        po_req = '0;
        check("prio", xfer_buffer, 16'h0077);
        tick();
        $display("test periph done");
        // last program address, then byte width with a slow answer
        load_buf(16'hFFFF);
        po(1'b1, 7'h40);
        fetch(4'h0, 16'hFFFF, 16'hFFFF ^ 16'h5A3C);
        rf_op(1'b1, RF_TABLE_WIDTH, 4'h1, 4'h0);
        rf_op(1'b0, RF_TABLE_WIDTH, 4'h0, 4'h1);
        load_buf(16'h9999);
        fetch(4'h3, 16'hFFFF, {8'h99, 8'hC3});
        $display("test fetch done");
        rst = 1'b1;
        repeat (2) tick();
        rst = 1'b0;
        tick();
        check("dir_rst2", port0a_dir, 4'h0);
        rf_op(1'b0, RF_TABLE_WIDTH, 4'h0, 4'h0);
        $display("test rereset done");
        final_report();
    end
endmodule // tb_data_buffer_peripheral_xfer
`default_nettype wire
